// [rtl/rwc_config_fuses.sv]
`timescale 1ns/1ps
`default_nettype none

//Contract
// [RULE1] Brown-out and watchdog bytes bits 7-4 read zero
// [RULE2] Brown-out bits 3:2 pick trip level
// [RULE3] Brown-out bit 1 enables brown-out reset
// [RULE4] Brown-out bit 0 low enables power-up delay
// [RULE5] Watchdog bits 3:1 pick postscale 1:2^n
// [RULE6] Watchdog bit 0 forces on, else software
// [RULE7] Wait bit set: no table wait states
// [RULE8] Wait bit clear: wait from control bits 5:4
// [RULE9] Mode bits 1:0 pick processor memory mode
// [RULE10] Mode byte bits 6-2 read zero
// [RULE11] Implemented mode bits programmable, unprogrammed read one
// [RULE12] Busless parts: programmer leaves mode bits set
// [RULE13] Programmed bit reads zero, unprogrammed reads one
// [RULE14] Config space at 300000h, table access only
// [RULE15] Write start runs self-timed one-byte write
module rwc_config_fuses #(
	parameter bit          EXT_BUS_PRESENT = 1'b1,
	parameter int unsigned WRITE_CYCLES    = rwc_pkg::LONG_WRITE_CYCLES
) (
	// Clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 resetn_i,
	// Table access port
	input  wire logic                 tbl_rd_i,
	input  wire logic                 table_write_op_i,
	input  wire rwc_pkg::rwc_tbl_req_s tbl_req_i,
	input  wire logic                 write_start_i,
	output logic [7:0]                tbl_rd_data_o,
	output logic                      tbl_rd_valid_o,
	output logic                      write_busy_o,
	output logic                      write_done_o,
	// Companion control inputs
	input  wire logic                 watchdog_soft_en_i,
	input  wire logic [7:0]           memory_interface_ctrl_i,
	// Brown-out and power-up options
	output logic [1:0]                brownout_level_sel_o,
	output logic                      brownout_rst_en_o,
	output logic                      powerup_delay_en_n_o,
	// Watchdog options
	output logic [2:0]                watchdog_postscale_sel_o,
	output logic [7:0]                watchdog_postscale_ratio_o,
	output logic                      watchdog_fuse_en_o,
	output logic                      watchdog_run_o,
	// External bus and processor mode
	output logic [1:0]                table_wait_count_o,
	output logic [1:0]                processor_mode_sel_o
);
	import rwc_pkg::*;

	// Maps a table address onto one of the three bytes
	function automatic rwc_sel_e cfg_select(input logic [ADDR_W-1:0] addr);
		rwc_sel_e sel;
		sel = RWC_SEL_NONE;
		if (addr == BROWNOUT_POWERUP_CONFIG_ADDR) begin
			sel = RWC_SEL_BROWNOUT;
		end else if (addr == WATCHDOG_CONFIG_ADDR) begin
			sel = RWC_SEL_WATCHDOG;
		end else if (addr == PROCESSOR_MODE_CONFIG_ADDR) begin
			sel = RWC_SEL_MODE;
		end
		return sel;
	endfunction

	// Reset synchroniser
	logic rst_meta_reg;   // First stage, read only by the second
	logic rst_n_sync;     // Released reset used everywhere else

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_reg <= 1'b0;
			rst_n_sync   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_sync   <= rst_meta_reg;
		end
	end

	// Configuration cells
	logic [7:0] bor_cfg_reg;   // Brown-out / power-up byte
	logic [7:0] wdt_cfg_reg;   // Watchdog byte
	logic [7:0] mode_cfg_reg;  // Processor mode byte

	// Pending table write
	rwc_tbl_req_s hold_reg;        // Latched address and data
	logic         hold_valid_reg;  // A table write is waiting
	rwc_sel_e     hold_sel;        // Byte the pending write hits

	// Read path
	rwc_sel_e   rd_sel;         // Byte the read addresses
	logic [7:0] rd_value;       // Selected byte
	logic [7:0] rd_data_reg;    // Registered read data
	logic       rd_valid_reg;   // Read answer strobe

	// Write sequencing
	logic timer_busy;     // Long write in progress
	logic timer_done;     // Long write just finished
	logic start_ok;       // Write start accepted
	logic mode_writable;  // Mode byte exists on this variant

	// Only exact table addresses reach the cells; nothing else can [RULE14]
	assign rd_sel   = cfg_select(tbl_req_i.addr);
	assign hold_sel = cfg_select(hold_reg.addr);

	// Without an external bus the mode byte is absent and stays set [RULE12]
	assign mode_writable = EXT_BUS_PRESENT;

	// Read mux; storage already holds zeros in unimplemented bits [RULE1] [RULE10]
	assign rd_value = (rd_sel == RWC_SEL_BROWNOUT) ? (bor_cfg_reg & BROWNOUT_IMPL_MASK) :
	                  (rd_sel == RWC_SEL_WATCHDOG) ? (wdt_cfg_reg & WATCHDOG_IMPL_MASK) :
	                  (rd_sel == RWC_SEL_MODE)     ? (mode_cfg_reg & MODE_IMPL_MASK) :
	                  8'h00;

	// A start needs a decoded pending write and an idle timer [RULE15]
	assign start_ok = write_start_i && hold_valid_reg && !timer_busy &&
	                  (hold_sel != RWC_SEL_NONE);

	// Registered read answer, one cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			rd_data_reg  <= 8'h00;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= tbl_rd_i;
			if (tbl_rd_i) begin
				rd_data_reg <= rd_value;
			end
		end
	end

	// Table write latch; frozen while a long write uses it
	always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			hold_reg       <= '0;
			hold_valid_reg <= 1'b0;
		end else if (table_write_op_i && !timer_busy) begin
			hold_reg       <= tbl_req_i;
			hold_valid_reg <= 1'b1;
		end else if (timer_done) begin
			// One latched write programs one byte only
			hold_valid_reg <= 1'b0;
		end
	end

	// Self-timed write window
	rwc_long_write_timer #(
		.CYCLES (WRITE_CYCLES)
	) u_write_timer (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_sync),
		.start_i   (start_ok),
		.busy_o    (timer_busy),
		.done_o    (timer_done)
	);

	// Cells start unprogrammed (implemented bits all ones); non-volatile retention is the
	// array's job, this model reloads the erased value on reset [RULE11] [RULE13]
	always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			bor_cfg_reg  <= BROWNOUT_RESET;
			wdt_cfg_reg  <= WATCHDOG_RESET;
			mode_cfg_reg <= MODE_RESET;
		end else if (timer_done) begin
			// Commit at end of window; a one or a zero may be written [RULE15]
			case (hold_sel)
				RWC_SEL_BROWNOUT: begin
					bor_cfg_reg <= hold_reg.data & BROWNOUT_IMPL_MASK; // [RULE1]
				end
				RWC_SEL_WATCHDOG: begin
					wdt_cfg_reg <= hold_reg.data & WATCHDOG_IMPL_MASK; // [RULE1]
				end
				RWC_SEL_MODE: begin
					if (mode_writable) begin
						mode_cfg_reg <= hold_reg.data & MODE_IMPL_MASK; // [RULE10] [RULE11]
					end
				end
				default: begin
					// Unmapped: nothing programmed
				end
			endcase
		end
	end

	// Bus answers
	assign tbl_rd_data_o  = rd_data_reg;
	assign tbl_rd_valid_o = rd_valid_reg;
	assign write_busy_o   = timer_busy;
	assign write_done_o   = timer_done;

	// Brown-out options straight from the cell
	assign brownout_level_sel_o = bor_cfg_reg[BOR_LEVEL_LSB +: 2]; // [RULE2]
	assign brownout_rst_en_o    = bor_cfg_reg[BOR_EN_BIT];         // [RULE3]
	assign powerup_delay_en_n_o = bor_cfg_reg[POWERUP_DELAY_TIMER_N_BIT];         // [RULE4]

	// Postscale as a one-hot ratio, 1:1 at code 0 up to 1:128 [RULE5]
	assign watchdog_postscale_sel_o   = wdt_cfg_reg[WDT_PS_LSB +: 3];
	assign watchdog_postscale_ratio_o = 8'h01 << watchdog_postscale_sel_o;

	// Fuse set forces the watchdog; otherwise software owns it [RULE6]
	assign watchdog_fuse_en_o = wdt_cfg_reg[WDT_EN_BIT];
	assign watchdog_run_o     = watchdog_fuse_en_o | watchdog_soft_en_i;

	// Wait states for table accesses on the external bus [RULE7] [RULE8]
	assign table_wait_count_o = mode_cfg_reg[MODE_WAIT_BIT] ? 2'h0 :
	                            memory_interface_ctrl_i[MEMIF_WAIT_LSB +: 2];

	// Processor memory mode [RULE9]
	assign processor_mode_sel_o = mode_cfg_reg[MODE_PM_LSB +: 2];

	// Checks
	localparam int WR_BOUND = 1000;  // Upper wait for a long write to finish

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_sync);

	sequence s_write_start;
		start_ok;
	endsequence

	sequence s_write_end;
		timer_done;
	endsequence

	a_bor_high_zero: assert property ( // [RULE1]
		tbl_rd_i && rd_sel == RWC_SEL_BROWNOUT |=> tbl_rd_data_o[7:4] == 4'h0)
		else $error("brown-out byte upper bits not zero");

	a_wdt_high_zero: assert property ( // [RULE1]
		tbl_rd_i && rd_sel == RWC_SEL_WATCHDOG |=> tbl_rd_data_o[7:4] == 4'h0)
		else $error("watchdog byte upper bits not zero");

	a_bor_fields_map: assert property ( // [RULE2]
		tbl_rd_i && rd_sel == RWC_SEL_BROWNOUT |=>
		tbl_rd_data_o[3:0] == {$past(brownout_level_sel_o), $past(brownout_rst_en_o),
		                       $past(powerup_delay_en_n_o)})
		else $error("brown-out fields disagree with read value");

	a_bor_en_follow: assert property ( // [RULE3]
		timer_done && hold_sel == RWC_SEL_BROWNOUT |=>
		brownout_rst_en_o == $past(hold_reg.data[BOR_EN_BIT]))
		else $error("brown-out enable not programmed");

	a_powerup_delay_timer_follow: assert property ( // [RULE4]
		timer_done && hold_sel == RWC_SEL_BROWNOUT |=>
		powerup_delay_en_n_o == $past(hold_reg.data[POWERUP_DELAY_TIMER_N_BIT]))
		else $error("power-up delay bit not programmed");

	a_postscale_ratio: assert property ( // [RULE5]
		$onehot(watchdog_postscale_ratio_o) &&
		watchdog_postscale_ratio_o[watchdog_postscale_sel_o])
		else $error("postscale ratio wrong");

	a_wdt_owner: assert property ( // [RULE6]
		!watchdog_fuse_en_o |-> watchdog_run_o == watchdog_soft_en_i)
		else $error("watchdog ownership wrong");

	a_wait_none: assert property ( // [RULE7]
		mode_cfg_reg[MODE_WAIT_BIT] |-> table_wait_count_o == 2'h0)
		else $error("wait states applied with wait bit set");

	a_wait_field: assert property ( // [RULE8]
		!mode_cfg_reg[MODE_WAIT_BIT] |->
		table_wait_count_o == memory_interface_ctrl_i[5:4])
		else $error("wait count not from control register");

	a_mode_read: assert property ( // [RULE9]
		tbl_rd_i && rd_sel == RWC_SEL_MODE |=>
		tbl_rd_data_o[1:0] == $past(processor_mode_sel_o))
		else $error("processor mode readback wrong");

	a_mode_mid_zero: assert property ( // [RULE10]
		tbl_rd_i && rd_sel == RWC_SEL_MODE |=> tbl_rd_data_o[6:2] == 5'h00)
		else $error("mode byte middle bits not zero");

	a_fresh_unprog: assert property ( // [RULE13]
		$rose(rst_n_sync) |-> bor_cfg_reg == 8'h0F && wdt_cfg_reg == 8'h0F &&
		mode_cfg_reg == 8'h83)
		else $error("cells not unprogrammed after reset");

	a_write_finish: assert property ( // [RULE15]
		write_busy_o && !write_done_o |=> write_busy_o)
		else $error("long write dropped busy before done");

	a_write_bound: assert property ( // [RULE15]
		s_write_start |-> ##[1:WR_BOUND] s_write_end)
		else $error("long write exceeded bound");

	a_write_commit: assert property ( // [RULE15]
		timer_done && hold_sel == RWC_SEL_WATCHDOG |=>
		wdt_cfg_reg == ($past(hold_reg.data) & 8'h0F))
		else $error("watchdog byte not committed");

	// An accepted start must open the window at once, never finish in it
	a_write_start_busy: assert property ( // [RULE15]
		s_write_start |=> write_busy_o && !write_done_o)
		else $error("accepted start did not raise busy");

	a_unmapped_read: assert property ( // [RULE14]
		tbl_rd_i && rd_sel == RWC_SEL_NONE |=> tbl_rd_valid_o && tbl_rd_data_o == 8'h00)
		else $error("unmapped table read not answered with zero");

	a_wdt_forced: assert property ( // [RULE6]
		watchdog_fuse_en_o |-> watchdog_run_o)
		else $error("fuse set but watchdog not running");

	a_postscale_top: assert property ( // [RULE5]
		watchdog_postscale_sel_o == 3'h7 |-> watchdog_postscale_ratio_o == 8'h80)
		else $error("postscale code seven not the longest ratio");

	// On a busless variant the mode byte must never leave its erased value
	a_mode_locked: assert property ( // [RULE12]
		!mode_writable |-> mode_cfg_reg == MODE_RESET)
		else $error("absent mode byte changed");

endmodule // rwc_config_fuses

`default_nettype wire

// [rtl/rwc_pkg.sv]
// Shared constants and types for the reset, watchdog and mode configuration bytes
package rwc_pkg;

	// Table access address width (configuration space tops out at 3FFFFFh)
	localparam int unsigned ADDR_W = 22;

	// Start of the configuration space
	localparam logic [ADDR_W-1:0] CFG_SPACE_BASE = 22'h300000;

	// Byte addresses of the three configuration bytes
	localparam logic [ADDR_W-1:0] BROWNOUT_POWERUP_CONFIG_ADDR = 22'h300002;
	localparam logic [ADDR_W-1:0] WATCHDOG_CONFIG_ADDR         = 22'h300003;
	localparam logic [ADDR_W-1:0] PROCESSOR_MODE_CONFIG_ADDR   = 22'h300004;

	// Implemented bits of each byte; unimplemented bits read as zero
	localparam logic [7:0] BROWNOUT_IMPL_MASK = 8'h0F;
	localparam logic [7:0] WATCHDOG_IMPL_MASK = 8'h0F;
	localparam logic [7:0] MODE_IMPL_MASK     = 8'h83;

	// Unprogrammed value: every implemented bit reads one
	localparam logic [7:0] BROWNOUT_RESET = 8'h0F;
	localparam logic [7:0] WATCHDOG_RESET = 8'h0F;
	localparam logic [7:0] MODE_RESET     = 8'h83;

	// Field positions in the brown-out / power-up byte
	localparam int unsigned BOR_LEVEL_LSB = 2;
	localparam int unsigned BOR_EN_BIT    = 1;
	localparam int unsigned POWERUP_DELAY_TIMER_N_BIT    = 0;

	// Field positions in the watchdog byte
	localparam int unsigned WDT_PS_LSB  = 1;
	localparam int unsigned WDT_EN_BIT  = 0;

	// Field positions in the mode byte
	localparam int unsigned MODE_WAIT_BIT = 7;
	localparam int unsigned MODE_PM_LSB   = 0;

	// Wait field position in the memory interface control register
	localparam int unsigned MEMIF_WAIT_LSB = 4;

	// Brown-out trip level codes
	localparam logic [1:0] BOR_LEVEL_2V5 = 2'h3;

	// Processor mode codes
	localparam logic [1:0] PM_ON_CHIP_ONLY   = 2'h3;
	localparam logic [1:0] PM_EXTERNAL       = 2'h2;
	localparam logic [1:0] PM_EXT_BOOT_BLOCK = 2'h1;
	localparam logic [1:0] PM_EXTENDED       = 2'h0;

	// Self-timed long write duration and its cycle count at 25 MHz
	localparam int unsigned LONG_WRITE_TIME_NS = 2000;
	localparam int unsigned CLK_PERIOD_NS      = 40;
	localparam int unsigned LONG_WRITE_CYCLES  =
		(LONG_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Which configuration byte an address selects
	typedef enum logic [1:0] {
		RWC_SEL_NONE,
		RWC_SEL_BROWNOUT,
		RWC_SEL_WATCHDOG,
		RWC_SEL_MODE
	} rwc_sel_e;

	// One table access: address and write data
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} rwc_tbl_req_s;

endpackage

// [rtl/rwc_long_write_timer.sv]
`timescale 1ns/1ps
`default_nettype none

// Self-timed write window: busy for CYCLES clocks and the one done pulse after them
module rwc_long_write_timer #(
	parameter int unsigned CYCLES = rwc_pkg::LONG_WRITE_CYCLES
) (
	// Clock and synchronised reset
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	// Control
	input  wire logic start_i,
	output logic      busy_o,
	output logic      done_o
);
	import rwc_pkg::*;

	localparam int unsigned CNT_W = $clog2(CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	logic [CNT_W-1:0] cnt_reg;   // Cycles left in the write
	logic [CNT_W-1:0] cnt_next;  // Next count
	logic             done_reg;  // Completion pulse
	logic             done_next; // Next completion

	// A start while the count runs is dropped; the caller already gates it
	assign cnt_next  = (start_i && (cnt_reg == '0)) ? CNT_LOAD :
	                   (cnt_reg != '0) ? cnt_reg - CNT_ONE : cnt_reg;
	assign done_next = (cnt_reg == CNT_ONE);

	// Down counter
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg  <= '0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign busy_o = (cnt_reg != '0) || done_reg;
	assign done_o = done_reg;

endmodule // rwc_long_write_timer

`default_nettype wire

// [verification/tb_rwc_config_fuses.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_rwc_config_fuses;
	import rwc_pkg::*;

	// Short write window keeps the run brief; every timing check derives from it
	localparam int unsigned WC = 3;

	// Clock, reset and design ports
	logic          sys_clk_i;
	logic          resetn_i;
	logic          tbl_rd_i;
	logic          table_write_op_i;
	rwc_tbl_req_s  tbl_req_i;
	logic          write_start_i;
	logic [7:0]    tbl_rd_data_o;
	logic          tbl_rd_valid_o;
	logic          write_busy_o;
	logic          write_done_o;
	logic          watchdog_soft_en_i;
	logic [7:0]    memory_interface_ctrl_i;
	logic [1:0]    brownout_level_sel_o;
	logic          brownout_rst_en_o;
	logic          powerup_delay_en_n_o;
	logic [2:0]    watchdog_postscale_sel_o;
	logic [7:0]    watchdog_postscale_ratio_o;
	logic          watchdog_fuse_en_o;
	logic          watchdog_run_o;
	logic [1:0]    table_wait_count_o;
	logic [1:0]    processor_mode_sel_o;

	// Bookkeeping
	int            n_mismatch;
	int            tests_run;
	int            cycles;

	rwc_config_fuses #(.EXT_BUS_PRESENT(1'b1), .WRITE_CYCLES(WC)) rwc_config_fuses_i (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .tbl_rd_i(tbl_rd_i),
		.table_write_op_i(table_write_op_i), .tbl_req_i(tbl_req_i),
		.write_start_i(write_start_i), .tbl_rd_data_o(tbl_rd_data_o),
		.tbl_rd_valid_o(tbl_rd_valid_o), .write_busy_o(write_busy_o),
		.write_done_o(write_done_o), .watchdog_soft_en_i(watchdog_soft_en_i),
		.memory_interface_ctrl_i(memory_interface_ctrl_i),
		.brownout_level_sel_o(brownout_level_sel_o), .brownout_rst_en_o(brownout_rst_en_o),
		.powerup_delay_en_n_o(powerup_delay_en_n_o),
		.watchdog_postscale_sel_o(watchdog_postscale_sel_o),
		.watchdog_postscale_ratio_o(watchdog_postscale_ratio_o),
		.watchdog_fuse_en_o(watchdog_fuse_en_o), .watchdog_run_o(watchdog_run_o),
		.table_wait_count_o(table_wait_count_o), .processor_mode_sel_o(processor_mode_sel_o)
	);

	// 25 MHz clock
	always #20 sys_clk_i = ~sys_clk_i;

	// Ceiling on run length; a hang counts as a mismatch
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles >= 5000) begin
			n_mismatch++;
			close_out();
		end
	end

	// Verdict and end of run
	task automatic close_out();
		$display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Single comparison point; case inequality so an unknown never matches
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One table read; data and valid are sampled one cycle after the request
	task automatic rd(input logic [21:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		#1;
		tbl_rd_i = 1'b1;
		tbl_req_i.addr = a;
		@(posedge sys_clk_i);
		#1;
		tbl_rd_i = 1'b0;
		chk({7'h00, tbl_rd_valid_o}, 8'h01);
		chk(tbl_rd_data_o, exp);
	endtask

	// Latch address and data of one byte write
	task automatic latch(input logic [21:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		#1;
		table_write_op_i = 1'b1;
		tbl_req_i = {a, d};
		@(posedge sys_clk_i);
		#1;
		table_write_op_i = 1'b0;
	endtask

	// Start the long write and time it: done comes WC edges after the start edge
	task automatic start_wait();
		int n;
		write_start_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		write_start_i = 1'b0;
		chk({7'h00, write_busy_o}, 8'h01);
		n = 0;
		while (write_done_o !== 1'b1 && n < 20) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		chk(8'(n), 8'(WC));
		@(posedge sys_clk_i);
		#1;
		chk({7'h00, write_busy_o}, 8'h00);
	endtask

	// Unprogrammed values after reset, unmapped read
	task automatic t_reset_values();
		rd(BROWNOUT_POWERUP_CONFIG_ADDR, 8'h0F);
		rd(WATCHDOG_CONFIG_ADDR, 8'h0F);
		rd(PROCESSOR_MODE_CONFIG_ADDR, 8'h83);
		rd(22'h300001, 8'h00);
		chk({5'h00, watchdog_postscale_sel_o}, 8'h07);
		chk({6'h00, processor_mode_sel_o}, 8'h03);
	endtask

	// Every trip level with alternating enable and delay bits; high bits discarded
	task automatic t_brownout();
		logic [7:0] v;
		for (int l = 0; l < 4; l++) begin
			v = {4'hA, 2'(l), l[0], ~l[0]};
			latch(BROWNOUT_POWERUP_CONFIG_ADDR, v);
			start_wait();
			chk({6'h00, brownout_level_sel_o}, 8'(l));
			chk({7'h00, brownout_rst_en_o}, {7'h00, l[0]});
			chk({7'h00, powerup_delay_en_n_o}, {7'h00, ~l[0]});
			rd(BROWNOUT_POWERUP_CONFIG_ADDR, v & 8'h0F);
		end
	endtask

	// Every postscale code; fuse cleared hands the run decision to software
	task automatic t_watchdog();
		for (int s = 0; s < 8; s++) begin
			latch(WATCHDOG_CONFIG_ADDR, {4'hF, 3'(s), 1'b0});
			start_wait();
			chk({5'h00, watchdog_postscale_sel_o}, 8'(s));
			chk(watchdog_postscale_ratio_o, 8'h01 << s);
			chk({7'h00, watchdog_fuse_en_o}, 8'h00);
			watchdog_soft_en_i = s[0];
			#1;
			chk({7'h00, watchdog_run_o}, {7'h00, s[0]});
			rd(WATCHDOG_CONFIG_ADDR, {4'h0, 3'(s), 1'b0});
		end
		watchdog_soft_en_i = 1'b0;
		latch(WATCHDOG_CONFIG_ADDR, 8'h01);
		start_wait();
		chk({7'h00, watchdog_run_o}, 8'h01);
	endtask

	// Every processor mode; the wait bit follows the low mode bit
	task automatic t_mode();
		logic [1:0] f;
		for (int m = 0; m < 4; m++) begin
			latch(PROCESSOR_MODE_CONFIG_ADDR, {m[0], 5'h1F, 2'(m)});
			start_wait();
			chk({6'h00, processor_mode_sel_o}, 8'(m));
			rd(PROCESSOR_MODE_CONFIG_ADDR, {m[0], 5'h00, 2'(m)});
			f = ~2'(m);
			memory_interface_ctrl_i = {2'b11, f, 4'hF};
			#1;
			chk({6'h00, table_wait_count_o}, m[0] ? 8'h00 : {6'h00, f});
		end
		// Leave every mode bit set again, as a busless part would need
		latch(PROCESSOR_MODE_CONFIG_ADDR, 8'hFF);
		start_wait();
		chk({6'h00, processor_mode_sel_o}, 8'h03);
		rd(PROCESSOR_MODE_CONFIG_ADDR, MODE_RESET);
	endtask

	// Refused starts, a read and a latch attempt while a write runs
	task automatic t_refusals();
		int seen_done;
		seen_done = 0;
		@(posedge sys_clk_i);
		#1;
		write_start_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		write_start_i = 1'b0;
		latch(22'h300001, 8'h00);
		write_start_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		write_start_i = 1'b0;
		repeat (WC + 2) begin
			@(posedge sys_clk_i);
			#1;
			seen_done += (write_busy_o !== 1'b0 || write_done_o !== 1'b0);
		end
		chk(8'(seen_done), 8'h00);
		latch(WATCHDOG_CONFIG_ADDR, 8'h06);
		write_start_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		write_start_i = 1'b0;
		table_write_op_i = 1'b1;
		tbl_req_i = {WATCHDOG_CONFIG_ADDR, 8'h0A};
		@(posedge sys_clk_i);
		#1;
		table_write_op_i = 1'b0;
		chk({7'h00, write_busy_o}, 8'h01);
		rd(WATCHDOG_CONFIG_ADDR, 8'h01);
		repeat (WC + 2) @(posedge sys_clk_i);
		rd(WATCHDOG_CONFIG_ADDR, 8'h06);
	endtask

	// Main sequence
	initial begin
		sys_clk_i = 1'b0;
		resetn_i = 1'b0;
		tbl_rd_i = 1'b0;
		table_write_op_i = 1'b0;
		tbl_req_i = '0;
		write_start_i = 1'b0;
		watchdog_soft_en_i = 1'b0;
		memory_interface_ctrl_i = 8'h00;
		n_mismatch = 0;
		tests_run = 0;
		cycles = 0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		resetn_i = 1'b1;
		// Synchroniser needs its edges before the first request
		repeat (3) @(posedge sys_clk_i);
		t_reset_values();
		t_brownout();
		t_watchdog();
		t_mode();
		t_refusals();
		close_out();
	end

endmodule // tb_rwc_config_fuses

`default_nettype wire
